// >>> rtl/tcf_pkg.sv
// constants for the compare-preload, comparator status, input filter and channel enable logic
// assumes a 32-bit axi4-lite slave port with byte addresses equal to four times a register index
package tcf_pkg;

  // register indices; byte address is index times four
  localparam logic [5:0] IDX_CMP1_PRELOAD = 6'h08;
  localparam logic [5:0] IDX_CMP2_PRELOAD = 6'h09;
  localparam logic [5:0] IDX_CMP_STATUS = 6'h0A;
  localparam logic [5:0] IDX_FILTER_CFG = 6'h0B;
  localparam logic [5:0] IDX_CHAN_ENABLE = 6'h0F;
  localparam logic [7:0] ADDR_CMP1_PRELOAD = {IDX_CMP1_PRELOAD, 2'b00};
  localparam logic [7:0] ADDR_CMP2_PRELOAD = {IDX_CMP2_PRELOAD, 2'b00};
  localparam logic [7:0] ADDR_CMP_STATUS = {IDX_CMP_STATUS, 2'b00};
  localparam logic [7:0] ADDR_FILTER_CFG = {IDX_FILTER_CFG, 2'b00};
  localparam logic [7:0] ADDR_CHAN_ENABLE = {IDX_CHAN_ENABLE, 2'b00};

  // comparator status/control fields
  localparam int CS_DBG_LO = 14;
  localparam int CS_FAULT = 13;
  localparam int CS_ALT = 12;
  localparam int CS_IE2 = 7;
  localparam int CS_IE1 = 6;
  localparam int CS_F2 = 5;
  localparam int CS_F1 = 4;
  localparam int CS_CL2_LO = 2;
  localparam int CS_CL1_LO = 0;
  localparam logic [15:0] CS_WRITE_MASK = 16'hF0CF;
  localparam logic [15:0] CS_RESET = 16'h0000;

  // compare-load codes and debug action bits
  localparam logic [1:0] CL_ON_CMP1 = 2'h1;
  localparam logic [1:0] CL_ON_CMP2 = 2'h2;
  localparam logic [1:0] CL_RESERVED = 2'h3;
  localparam int DBG_HALT_BIT = 0;
  localparam int DBG_FORCE_BIT = 1;

  // input filter fields
  localparam int FILTER_SAMPLE_COUNT_LO = 8;
  localparam int FILTER_SAMPLE_PERIOD_LO = 0;
  localparam logic [15:0] FILT_WRITE_MASK = 16'h07FF;
  localparam logic [15:0] FILT_RESET = 16'h0000;
  localparam logic [3:0] FILTER_SAMPLE_COUNT_BASE = 4'h3;

  // channel enable
  localparam int NUM_CHAN = 4;
  localparam logic [15:0] ENABLE_WRITE_MASK = 16'h000F;
  localparam logic [15:0] ENABLE_RESET = 16'h000F;
  localparam logic [15:0] PRELOAD_RESET = 16'h0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tcf_pkg

// >>> rtl/tcf_channel_ext.sv
// compare preloads, comparator status/control, input glitch filter and channel enables
// assumes compare, reinit and count-mode signals come from counter logic on aclk;
// the secondary input and debug request arrive asynchronously and are synchronised here
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none

module tcf_channel_ext
  import tcf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic compare1_event,
  input wire logic compare2_event,
  input wire logic count_down,
  input wire logic reinit_request,
  input wire logic [15:0] reload_value_register,
  input wire logic [NUM_CHAN-1:0] count_mode_nonzero,
  input wire logic debug_mode,
  input wire logic secondary_input_pin,
  output logic compare1_load,
  output logic [15:0] compare1_load_value,
  output logic compare2_load,
  output logic [15:0] compare2_load_value,
  output logic counter_reload,
  output logic [15:0] counter_reload_value,
  output logic timer_output_flag_clear,
  output logic halt_counter,
  output logic force_output_zero,
  output logic [NUM_CHAN-1:0] counter_run,
  output logic filtered_input,
  output logic irq_request
);

  logic [15:0] compare_one_preload;
  logic [15:0] compare_two_preload;
  logic [15:0] comparator_status_control;
  logic [15:0] input_filter_config;
  logic [15:0] channel_enable;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic [31:0] next_rdata;
  logic next_rhit;
  logic [1:0] debug_action_select;
  logic alternate_reload;
  logic compare1_flag;
  logic compare2_flag;
  logic [1:0] compare1_load_control;
  logic [1:0] compare2_load_control;
  logic [2:0] filter_sample_count;
  logic [7:0] filter_sample_period;
  logic [NUM_CHAN-1:0] channel_enable_bits;
  logic clr_flag1;
  logic clr_flag2;
  logic in_meta;
  logic in_sync;
  logic dbg_meta;
  logic dbg_sync;
  logic [7:0] per_cnt;
  logic [3:0] agree_cnt;
  logic [3:0] filt_need;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    merge16 = (v & mask) | (old & ~mask);
  endfunction : merge16
  assign debug_action_select = comparator_status_control[CS_DBG_LO +: 2];
  assign alternate_reload = comparator_status_control[CS_ALT];
  assign compare1_flag = comparator_status_control[CS_F1];
  assign compare2_flag = comparator_status_control[CS_F2];
  assign compare1_load_control = comparator_status_control[CS_CL1_LO +: 2];
  assign compare2_load_control = comparator_status_control[CS_CL2_LO +: 2];
  assign filter_sample_count = input_filter_config[FILTER_SAMPLE_COUNT_LO +: 3];
  assign filter_sample_period = input_filter_config[FILTER_SAMPLE_PERIOD_LO +: 8];
  assign channel_enable_bits = channel_enable[NUM_CHAN-1:0];
  assign filt_need = {1'b0, filter_sample_count} + FILTER_SAMPLE_COUNT_BASE;
  // write channel: address and data taken in either order, response after both
  assign wr_fire = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        if (wr_addr == ADDR_CMP1_PRELOAD || wr_addr == ADDR_CMP2_PRELOAD || wr_addr == ADDR_CMP_STATUS ||
            wr_addr == ADDR_FILTER_CFG || wr_addr == ADDR_CHAN_ENABLE) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rhit = 1'b1;
    if (araddr == ADDR_CMP1_PRELOAD) begin
      next_rdata[15:0] = compare_one_preload;
    end else if (araddr == ADDR_CMP2_PRELOAD) begin
      next_rdata[15:0] = compare_two_preload;
    end else if (araddr == ADDR_CMP_STATUS) begin
      next_rdata[15:0] = comparator_status_control;
    end else if (araddr == ADDR_FILTER_CFG) begin
      next_rdata[15:0] = input_filter_config;
    end else if (araddr == ADDR_CHAN_ENABLE) begin
      next_rdata[15:0] = channel_enable;
    end else begin
      next_rhit = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= next_rhit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_one_preload <= PRELOAD_RESET;
      compare_two_preload <= PRELOAD_RESET;
    end else if (wr_fire) begin
      if (wr_addr == ADDR_CMP1_PRELOAD) begin
        compare_one_preload <= merge16(compare_one_preload, wr_data, wr_strb, 16'hFFFF);
      end
      if (wr_addr == ADDR_CMP2_PRELOAD) begin
        compare_two_preload <= merge16(compare_two_preload, wr_data, wr_strb, 16'hFFFF);
      end
    end
  end

  // zero written into a flag lane clears it
  assign clr_flag1 = wr_fire && wr_addr == ADDR_CMP_STATUS && wr_strb[0] && !wr_data[CS_F1];
  assign clr_flag2 = wr_fire && wr_addr == ADDR_CMP_STATUS && wr_strb[0] && !wr_data[CS_F2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comparator_status_control <= CS_RESET;
    end else begin
      if (wr_fire && wr_addr == ADDR_CMP_STATUS) begin
        comparator_status_control <= merge16(comparator_status_control, wr_data, wr_strb, CS_WRITE_MASK);
      end
      // compare one flag, set beats clear
      comparator_status_control[CS_F1] <= compare1_event || (compare1_flag && !clr_flag1);
      // compare two flag, set beats clear
      comparator_status_control[CS_F2] <= compare2_event || (compare2_flag && !clr_flag2);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_filter_config <= FILT_RESET;
    end else if (wr_fire && wr_addr == ADDR_FILTER_CFG) begin
      input_filter_config <= merge16(input_filter_config, wr_data, wr_strb, FILT_WRITE_MASK);
    end
  end

  // all channels enabled out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_enable <= ENABLE_RESET;
    end else if (wr_fire && wr_addr == ADDR_CHAN_ENABLE) begin
      channel_enable <= merge16(channel_enable, wr_data, wr_strb, ENABLE_WRITE_MASK);
    end
  end

  // one register gates all counters, each channel by its own enable bit and its nonzero count mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_run <= '0;
    end else begin
      counter_run <= channel_enable_bits & count_mode_nonzero;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare1_load <= 1'b0;
      compare2_load <= 1'b0;
      compare1_load_value <= PRELOAD_RESET;
      compare2_load_value <= PRELOAD_RESET;
    end else begin
      compare1_load <= (compare1_load_control == CL_ON_CMP1 && compare1_event) ||
                       (compare1_load_control == CL_ON_CMP2 && compare2_event);
      compare2_load <= (compare2_load_control == CL_ON_CMP1 && compare1_event) ||
                       (compare2_load_control == CL_ON_CMP2 && compare2_event);
      compare1_load_value <= compare_one_preload;
      compare2_load_value <= compare_two_preload;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_reload <= 1'b0;
      counter_reload_value <= PRELOAD_RESET;
    end else begin
      counter_reload <= reinit_request;
      if (reinit_request) begin
        if (alternate_reload && count_down && compare2_event) begin
          counter_reload_value <= compare_two_preload;
        end else begin
          counter_reload_value <= reload_value_register;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
      halt_counter <= 1'b0;
      force_output_zero <= 1'b0;
    end else begin
      dbg_meta <= debug_mode;
      dbg_sync <= dbg_meta;
      halt_counter <= dbg_sync && debug_action_select[DBG_HALT_BIT];
      force_output_zero <= dbg_sync && debug_action_select[DBG_FORCE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= (comparator_status_control[CS_IE1] && compare1_flag) ||
                     (comparator_status_control[CS_IE2] && compare2_flag);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      per_cnt <= 8'h01;
      agree_cnt <= 4'h0;
      filtered_input <= 1'b0;
    end else begin
      in_meta <= secondary_input_pin;
      in_sync <= in_meta;
      if (filter_sample_period == 8'h00) begin
        per_cnt <= 8'h01;
        agree_cnt <= 4'h0;
        filtered_input <= in_sync;
      end else if (per_cnt >= filter_sample_period) begin
        per_cnt <= 8'h01;
        if (in_sync == filtered_input) begin
          agree_cnt <= 4'h0;
        end else if (agree_cnt + 4'h1 >= filt_need) begin
          agree_cnt <= 4'h0;
          filtered_input <= in_sync;
        end else begin
          agree_cnt <= agree_cnt + 4'h1;
        end
      end else begin
        per_cnt <= per_cnt + 8'h01;
      end
    end
  end

  // fault input clears the output flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_flag_clear <= 1'b0;
    end else begin
      timer_output_flag_clear <= comparator_status_control[CS_FAULT] && filtered_input;
    end
  end

  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  sequence s_cmp1_reload_sel;
    compare1_event && compare1_load_control == CL_ON_CMP1;
  endsequence
  a_flag1_set: assert property (@(posedge aclk) disable iff (!aresetn)
    compare1_event |=> compare1_flag) else $error("compare one flag not set");
  a_flag2_set: assert property (@(posedge aclk) disable iff (!aresetn)
    compare2_event |=> compare2_flag) else $error("compare two flag not set");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    compare1_flag && !clr_flag1 |=> compare1_flag) else $error("compare one flag lost");
  a_irq_map: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq_request == ($past(comparator_status_control[CS_IE1] && compare1_flag) ||
                        $past(comparator_status_control[CS_IE2] && compare2_flag)))
    else $error("interrupt request mismatch");
  a_cmp1_preload: assert property (@(posedge aclk) disable iff (!aresetn)
    s_cmp1_reload_sel |=> compare1_load && compare1_load_value == $past(compare_one_preload))
    else $error("compare one preload missed");
  a_cmp2_never: assert property (@(posedge aclk) disable iff (!aresetn)
    compare2_load_control == 2'h0 || compare2_load_control == CL_RESERVED |=> !compare2_load)
    else $error("compare two loaded while disabled");
  a_alt_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    reinit_request && alternate_reload && count_down && compare2_event
    |=> counter_reload && counter_reload_value == $past(compare_two_preload))
    else $error("alternate reload value wrong");
  a_plain_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    reinit_request && !alternate_reload |=> counter_reload_value == $past(reload_value_register))
    else $error("reload not from load register");
  a_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !channel_enable_bits[0] |=> !counter_run[0]) else $error("disabled channel running");
  a_fault_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    comparator_status_control[CS_FAULT] && filtered_input |=> timer_output_flag_clear)
    else $error("fault did not clear output flag");
  a_filter_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    filter_sample_period == 8'h00 |=> filtered_input == $past(in_sync))
    else $error("bypassed filter output wrong");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ar_taken |=> rvalid && !arready) else $error("read answer late");
endmodule : tcf_channel_ext

`default_nettype wire

// >>> verif/timer_compare_filter_enable_test.sv
// testbench for the compare preload, comparator status, input filter and channel enable logic
// assumes tcf_pkg and tcf_channel_ext are compiled first; drives every port of the block itself
`timescale 1ns/100ps
`default_nettype none

module timer_compare_filter_enable_test
  import tcf_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic compare1_event = 1'b0, compare2_event = 1'b0, count_down = 1'b0, reinit_request = 1'b0;
  logic [15:0] reload_value_register = 16'h0000;
  logic [NUM_CHAN-1:0] count_mode_nonzero = 4'h0;
  logic debug_mode = 1'b0, secondary_input_pin = 1'b0;
  logic compare1_load, compare2_load, counter_reload, timer_output_flag_clear;
  logic [15:0] compare1_load_value, compare2_load_value, counter_reload_value;
  logic halt_counter, force_output_zero, filtered_input, irq_request;
  logic [NUM_CHAN-1:0] counter_run;
  int num_errors = 0;
  int checks_done = 0;

  always #25 aclk = ~aclk;

  tcf_channel_ext dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .compare1_event(compare1_event), .compare2_event(compare2_event), .count_down(count_down),
    .reinit_request(reinit_request), .reload_value_register(reload_value_register),
    .count_mode_nonzero(count_mode_nonzero), .debug_mode(debug_mode),
    .secondary_input_pin(secondary_input_pin), .compare1_load(compare1_load),
    .compare1_load_value(compare1_load_value), .compare2_load(compare2_load),
    .compare2_load_value(compare2_load_value), .counter_reload(counter_reload),
    .counter_reload_value(counter_reload_value), .timer_output_flag_clear(timer_output_flag_clear),
    .halt_counter(halt_counter), .force_output_zero(force_output_zero), .counter_run(counter_run),
    .filtered_input(filtered_input), .irq_request(irq_request));

  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick

  task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    resp = 2'h1;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hF;
    bready <= 1'b1;
    // waits for the answer; only the watchdog ends a hang
    forever begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit ar_done;
    ar_done = 0;
    d = 32'hFFFF_FFFF;
    resp = 2'h1;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check("read data", d, {16'h0000, exp});
    check("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rd_check

  task automatic pulse(input logic e1, input logic e2, input logic ri);
    @(posedge aclk);
    compare1_event <= e1;
    compare2_event <= e2;
    reinit_request <= ri;
    @(posedge aclk);
    compare1_event <= 1'b0;
    compare2_event <= 1'b0;
    reinit_request <= 1'b0;
    #1;
  endtask : pulse

  task automatic test_reset_values;
    logic [31:0] d;
    logic [1:0] r;
    rd_check(ADDR_CHAN_ENABLE, 16'h000F);
    rd_check(ADDR_CMP1_PRELOAD, 16'h0000);
    rd_check(ADDR_CMP_STATUS, 16'h0000);
    rd_check(ADDR_FILTER_CFG, 16'h0000);
    axi_read(8'h30, d, r);
    check("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(8'h30, 16'h1234, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : test_reset_values

  task automatic test_preload;
    wr(ADDR_CMP1_PRELOAD, 16'h1234);
    wr(ADDR_CMP2_PRELOAD, 16'hABCD);
    rd_check(ADDR_CMP1_PRELOAD, 16'h1234);
    rd_check(ADDR_CMP2_PRELOAD, 16'hABCD);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CMP_STATUS, {12'h000, c[1:0], c[1:0]});
      pulse(1'b1, 1'b0, 1'b0);
      check("load1 on cmp1", {31'h0, compare1_load}, {31'h0, c == 1});
      check("load2 on cmp1", {31'h0, compare2_load}, {31'h0, c == 1});
      pulse(1'b0, 1'b1, 1'b0);
      check("load1 on cmp2", {31'h0, compare1_load}, {31'h0, c == 2});
      check("load2 on cmp2", {31'h0, compare2_load}, {31'h0, c == 2});
      if (c == 2) begin
        check("load1 value", {16'h0, compare1_load_value}, 32'h0000_1234);
        check("load2 value", {16'h0, compare2_load_value}, 32'h0000_ABCD);
      end
    end
  endtask : test_preload

  task automatic test_flags;
    wr(ADDR_CMP_STATUS, 16'h0000);
    pulse(1'b1, 1'b0, 1'b0);
    tick(2);
    check("irq masked", {31'h0, irq_request}, 32'h0);
    wr(ADDR_CMP_STATUS, 16'h0050);
    tick(2);
    check("irq flag1", {31'h0, irq_request}, 32'h1);
    pulse(1'b0, 1'b1, 1'b0);
    rd_check(ADDR_CMP_STATUS, 16'h0070);
    wr(ADDR_CMP_STATUS, 16'h00B0);
    rd_check(ADDR_CMP_STATUS, 16'h00B0);
    wr(ADDR_CMP_STATUS, 16'h0080);
    rd_check(ADDR_CMP_STATUS, 16'h0080);
    tick(2);
    check("irq cleared", {31'h0, irq_request}, 32'h0);
    pulse(1'b0, 1'b1, 1'b0);
    tick(2);
    check("irq flag2", {31'h0, irq_request}, 32'h1);
    wr(ADDR_CMP_STATUS, 16'h0000);
    rd_check(ADDR_CMP_STATUS, 16'h0000);
    fork
      wr(ADDR_CMP_STATUS, 16'h0000);
      begin
        repeat (2) @(posedge aclk);
        compare2_event <= 1'b1;
        @(posedge aclk);
        compare2_event <= 1'b0;
      end
    join
    rd_check(ADDR_CMP_STATUS, 16'h0020);
  endtask : test_flags

  task automatic test_debug;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CMP_STATUS, {d[1:0], 14'h0000});
      @(posedge aclk);
      debug_mode <= 1'b1;
      tick(5);
      check("halt in debug", {31'h0, halt_counter}, {31'h0, d[0]});
      check("force in debug", {31'h0, force_output_zero}, {31'h0, d[1]});
      @(posedge aclk);
      debug_mode <= 1'b0;
      tick(5);
      check("halt out of debug", {31'h0, halt_counter}, 32'h0);
      check("force out of debug", {31'h0, force_output_zero}, 32'h0);
    end
  endtask : test_debug

  task automatic test_fault;
    wr(ADDR_CMP_STATUS, 16'h0000);
    @(posedge aclk);
    secondary_input_pin <= 1'b1;
    tick(5);
    check("bypass filter", {31'h0, filtered_input}, 32'h1);
    check("fault off", {31'h0, timer_output_flag_clear}, 32'h0);
    wr(ADDR_CMP_STATUS, 16'h2000);
    tick(2);
    check("fault on", {31'h0, timer_output_flag_clear}, 32'h1);
    @(posedge aclk);
    secondary_input_pin <= 1'b0;
    tick(6);
    check("fault released", {31'h0, timer_output_flag_clear}, 32'h0);
    wr(ADDR_CMP_STATUS, 16'h0000);
  endtask : test_fault

  task automatic test_reload;
    @(posedge aclk);
    reload_value_register <= 16'h1111;
    count_down <= 1'b1;
    pulse(1'b0, 1'b1, 1'b1);
    check("reload pulse", {31'h0, counter_reload}, 32'h1);
    check("plain reload", {16'h0, counter_reload_value}, 32'h0000_1111);
    wr(ADDR_CMP_STATUS, 16'h1000);
    pulse(1'b0, 1'b1, 1'b1);
    check("alt down reload", {16'h0, counter_reload_value}, 32'h0000_ABCD);
    @(posedge aclk);
    count_down <= 1'b0;
    pulse(1'b1, 1'b0, 1'b1);
    check("alt up reload", {16'h0, counter_reload_value}, 32'h0000_1111);
    wr(ADDR_CMP_STATUS, 16'h0000);
  endtask : test_reload

  task automatic test_filter;
    int n, lo, hi;
    int cfg[2][2] = '{'{0, 2}, '{7, 1}};
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_FILTER_CFG, {5'h00, cfg[i][0][2:0], cfg[i][1][7:0]});
      rd_check(ADDR_FILTER_CFG, {5'h00, cfg[i][0][2:0], cfg[i][1][7:0]});
      lo = (cfg[i][0] + 2) * cfg[i][1] + 2;
      hi = (cfg[i][0] + 3) * cfg[i][1] + 2 + cfg[i][1] + 4;
      @(posedge aclk);
      secondary_input_pin <= 1'b1;
      n = 0;
      #1;
      while (filtered_input !== 1'b1 && n < 200) begin tick(1); n++; end
      check("filter latency low", {31'h0, n >= lo}, 32'h1);
      check("filter latency high", {31'h0, n <= hi}, 32'h1);
      @(posedge aclk);
      secondary_input_pin <= 1'b0;
      tick(40);
      check("filter fall", {31'h0, filtered_input}, 32'h0);
    end
    wr(ADDR_FILTER_CFG, 16'h0004);
    @(posedge aclk);
    secondary_input_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    secondary_input_pin <= 1'b0;
    n = 0;
    for (int k = 0; k < 30; k++) begin tick(1); n += (filtered_input !== 1'b0); end
    check("glitch rejected", n, 0);
    wr(ADDR_FILTER_CFG, 16'h0000);
  endtask : test_filter

  task automatic test_enable;
    @(posedge aclk);
    count_mode_nonzero <= 4'hF;
    tick(3);
    check("run after reset", {28'h0, counter_run}, 32'hF);
    wr(ADDR_CHAN_ENABLE, 16'h0000);
    tick(3);
    check("all held", {28'h0, counter_run}, 32'h0);
    wr(ADDR_CHAN_ENABLE, 16'hFFF5);
    rd_check(ADDR_CHAN_ENABLE, 16'h0005);
    check("joint start", {28'h0, counter_run}, 32'h5);
    @(posedge aclk);
    count_mode_nonzero <= 4'h3;
    tick(3);
    check("mode gate", {28'h0, counter_run}, 32'h1);
    wr(ADDR_CHAN_ENABLE, 16'h000F);
  endtask : test_enable

  initial begin
    #(50 * 20000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset_values();
    test_preload();
    test_flags();
    test_debug();
    test_fault();
    test_reload();
    test_filter();
    test_enable();
    report_and_stop();
  end
endmodule : timer_compare_filter_enable_test

`default_nettype wire
